// File: rtl/vrt_front.sv
// Address front end: low-address remap, context_identifier_reg, translation buffer.
// Assumes core, walker and trace sink all run on REF_CLK.
`timescale 1ns/1ps
module vrt_front
    import vrt_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // Coprocessor transfer
    input  wire logic        CP_VALID,
    input  wire logic        CP_WRITE,
    input  wire logic [3:0]  CP_CRN,
    input  wire logic [2:0]  CP_OP2,
    input  wire logic [31:0] CP_WDATA,
    output logic      [31:0] CP_RDATA,
    output logic             CP_RDVALID,
    // Translation control
    input  wire logic        MMU_ENABLE,
    input  wire logic [31:0] DOMAIN_ACCESS,
    input  wire logic        FETCH_STROBE,
    // Core access
    input  wire logic        ACC_VALID,
    input  wire logic [31:0] ACC_VA,
    input  wire logic        ACC_WRITE,
    input  wire logic        ACC_PRIV,
    output logic             ACC_BUSY,
    output logic             ACC_DONE,
    output logic             ACC_ABORT,
    output logic      [31:0] ACC_MVA,
    output logic      [31:0] ACC_PA,
    output logic             ACC_CACHABLE,
    output logic             ACC_BUFFERABLE,
    // Table walk
    output logic             WALK_REQ,
    output logic      [31:0] WALK_MVA,
    input  wire logic        WALK_DONE,
    input  wire logic        WALK_FAULT,
    input  wire logic [21:0] WALK_BASE,
    input  wire logic [1:0]  WALK_SIZE,
    input  wire logic [3:0]  WALK_DOMAIN,
    input  wire logic [7:0]  WALK_AP,
    input  wire logic [1:0]  WALK_CB,
    // Trace
    output logic      [31:0] TRACE_CONTEXT,
    output logic             TRACE_CONTEXT_WR
);

    vrt_ram_if ram_bus ();

    vrt_tlb_ram #(
        .SETS_P (TLB_SETS)
    ) u_ram (
        .clk (REF_CLK),
        .bus (ram_bus.ram)
    );

    vrt_state_t          state_reg;
    logic [PID_W-1:0]    pid_reg;
    logic [PID_W-1:0]    pid_old_reg;
    logic [1:0]          pend_reg;
    logic [PID_W-1:0]    pid_eff;
    logic [VICTIM_W-1:0] victim_reg;
    logic                preserve_reg;
    logic                inv_pend_reg;
    logic [31:0]         inv_mva_reg;
    logic [31:0]         mva_reg;
    logic [31:0]         mva_in;
    logic                wr_reg;
    logic                priv_reg;
    logic [TLB_SETS-1:0] vld_reg [2];
    logic [TLB_SETS-1:0] rr_reg;
    vrt_entry_t          lk_ent [LOCK_ENTRIES];
    logic [LOCK_ENTRIES-1:0] lk_vld_reg;
    logic [LOCK_ENTRIES-1:0] lk_hit;
    logic [1:0]          way_hit;
    logic [31:0]         cmp_mva;
    logic [IDX_W-1:0]    cmp_idx;
    logic [IDX_W-1:0]    idx_reg;
    vrt_entry_t          hit_entry;
    vrt_entry_t          walk_entry;
    vrt_entry_t          res_entry;
    logic                any_hit;
    logic                answer;
    logic                res_abort;
    logic                cp_rd;
    logic                cp_wr;
    logic                pid_wr;
    logic                ctx_wr;
    logic                lock_wr;
    logic                inv_all;
    logic                inv_one;
    logic                walk_ok;
    logic                fill_main;
    logic                fill_lock;

    function automatic logic [TAG_W-1:0] size_mask(input logic [1:0] sz);
        case (sz)
            SZ_SECTION: return MASK_SECTION;
            SZ_LARGE:   return MASK_LARGE;
            SZ_SMALL:   return MASK_SMALL;
            default:    return MASK_TINY;
        endcase
    endfunction

    function automatic logic tag_hit(input vrt_entry_t e,
                                     input logic [31:0] a);
        logic [TAG_W-1:0] m;
        m = size_mask(e.size);
        return ((e.tag ^ a[31:PAGE_LSB]) & m) == '0;
    endfunction

    function automatic logic [31:0] phys(input vrt_entry_t e,
                                         input logic [31:0] a);
        logic [TAG_W-1:0] m;
        m = size_mask(e.size);
        return {(e.pa & m) | (a[31:PAGE_LSB] & ~m), a[PAGE_LSB-1:0]};
    endfunction

    // S and R bits are not modelled, so a no-access code aborts in every client domain
    function automatic logic denied(input vrt_entry_t e,
                                    input logic [31:0] a,
                                    input logic wr,
                                    input logic priv);
        logic [1:0] dom;
        logic [1:0] sub;
        logic [1:0] ap;
        dom = DOMAIN_ACCESS[2 * e.domain +: 2];
        sub = (e.size == SZ_LARGE) ? a[SUB_LARGE_LSB +: 2] :
              (e.size == SZ_SMALL) ? a[SUB_SMALL_LSB +: 2] : 2'h0;
        ap  = e.ap[2 * sub +: 2];
        if (dom == DOM_MANAGER)
            return 1'b0;
        if (dom != DOM_CLIENT)
            return 1'b1;
        case (ap)
            AP_NONE:    return 1'b1;
            AP_PRIV:    return !priv;
            AP_USER_RO: return !priv && wr;
            default:    return 1'b0;
        endcase
    endfunction

    // Coprocessor decode; register 14 falls through untouched
    assign cp_wr   = CP_VALID && CP_WRITE;
    assign cp_rd   = CP_VALID && !CP_WRITE;
    assign pid_wr  = cp_wr && CP_CRN == CRN_PROCESS
                     && CP_OP2 == OP2_REMAP_ID;
    assign ctx_wr  = cp_wr && CP_CRN == CRN_PROCESS
                     && CP_OP2 == OP2_CONTEXT;
    assign lock_wr = cp_wr && CP_CRN == CRN_LOCKDOWN;
    assign inv_all = cp_wr && CP_CRN == CRN_TLB_OPS
                     && CP_OP2 == OP2_INV_ALL;
    assign inv_one = cp_wr && CP_CRN == CRN_TLB_OPS
                     && CP_OP2 == OP2_INV_ONE;

    // Old id holds until two more fetches have gone out
    assign pid_eff = (pend_reg != 2'h0) ? pid_old_reg : pid_reg;

    // Remap only low addresses, and only with translation on
    always_comb
    begin
        mva_in = ACC_VA;
        if (MMU_ENABLE && ACC_VA[31:PID_LSB] == '0)
            mva_in = {pid_eff, ACC_VA[PID_LSB-1:0]};
    end

    assign ACC_MVA  = mva_reg;
    assign WALK_MVA = mva_reg;
    assign idx_reg  = mva_reg[IDX_LSB +: IDX_W];
    assign cmp_mva  = (state_reg == ST_INV) ? inv_mva_reg : mva_reg;
    assign cmp_idx  = cmp_mva[IDX_LSB +: IDX_W];

    assign walk_entry = '{tag: mva_reg[31:PAGE_LSB], pa: WALK_BASE,
                          size: WALK_SIZE, domain: WALK_DOMAIN,
                          ap: WALK_AP, cb: WALK_CB};
    assign walk_ok   = state_reg == ST_WALK && WALK_DONE && !WALK_FAULT;
    assign fill_main = walk_ok && !preserve_reg;
    assign fill_lock = walk_ok && preserve_reg;

    // Memory port: one unified store for fetches and data
    always_comb
    begin
        ram_bus.rd_en   = state_reg == ST_IDLE;
        ram_bus.rd_idx  = ACC_VALID ? mva_in[IDX_LSB +: IDX_W]
                                    : inv_mva_reg[IDX_LSB +: IDX_W];
        ram_bus.wr_en   = fill_main;
        ram_bus.wr_way  = rr_reg[idx_reg];
        ram_bus.wr_idx  = idx_reg;
        ram_bus.wr_data = walk_entry;
    end

    // Compare both ways and all locked entries in parallel
    always_comb
    begin
        hit_entry = ram_bus.rd_data[1];
        for (int w = 0; w < 2; w++)
            way_hit[w] = vld_reg[w][cmp_idx]
                         && tag_hit(ram_bus.rd_data[w], cmp_mva);
        if (way_hit[0])
            hit_entry = ram_bus.rd_data[0];
        for (int i = LOCK_ENTRIES - 1; i >= 0; i--)
        begin
            lk_hit[i] = lk_vld_reg[i] && tag_hit(lk_ent[i], cmp_mva);
            if (lk_hit[i])
                hit_entry = lk_ent[i];
        end
    end

    assign any_hit   = (|lk_hit) || (|way_hit);
    assign answer    = (state_reg == ST_LOOK && any_hit)
                       || (state_reg == ST_WALK && WALK_DONE);
    assign res_entry = (state_reg == ST_WALK) ? walk_entry : hit_entry;
    assign res_abort = (state_reg == ST_WALK && WALK_FAULT)
                       || denied(res_entry, mva_reg, wr_reg, priv_reg);

    // Remap id; a change leaves every buffer entry valid
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            pid_reg     <= PID_RESET;
            pid_old_reg <= PID_RESET;
            pend_reg    <= 2'h0;
        end
        else if (pid_wr)
        begin
            pid_old_reg <= pid_eff;
            pid_reg     <= CP_WDATA[PID_LSB +: PID_W];
            pend_reg    <= FETCH_HOLD;
        end
        else if (FETCH_STROBE && pend_reg != 2'h0)
        begin
            pend_reg <= pend_reg - 2'h1;
        end
    end

    // Context_identifier_reg and its trace mirror
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            TRACE_CONTEXT    <= CONTEXT_RESET;
            TRACE_CONTEXT_WR <= 1'b0;
        end
        else
        begin
            TRACE_CONTEXT_WR <= ctx_wr;
            if (ctx_wr)
                TRACE_CONTEXT <= CP_WDATA;
        end
    end

    // Read-back, one cycle after the request
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            CP_RDVALID <= 1'b0;
            CP_RDATA   <= 32'h0;
        end
        else
        begin
            CP_RDVALID <= cp_rd;
            if (cp_rd)
            begin
                case (CP_CRN)
                    CRN_PROCESS:
                        CP_RDATA <= (CP_OP2 == OP2_CONTEXT) ? TRACE_CONTEXT
                                  : {pid_reg, 25'h0};
                    CRN_LOCKDOWN:
                        CP_RDATA <= {3'h0, victim_reg, 25'h0, preserve_reg};
                    CRN_RESERVED:
                        CP_RDATA <= 32'h0;
                    default:
                        CP_RDATA <= 32'h0;
                endcase
            end
        end
    end

    // Pending single invalidate; a new request beats the clear
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            inv_pend_reg <= 1'b0;
            inv_mva_reg  <= 32'h0;
        end
        else if (inv_one)
        begin
            inv_pend_reg <= 1'b1;
            inv_mva_reg  <= CP_WDATA;
        end
        else if (state_reg == ST_INV)
        begin
            inv_pend_reg <= 1'b0;
        end
    end

    // Main part valid bits and replacement pointers
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            vld_reg[0] <= '0;
            vld_reg[1] <= '0;
            rr_reg     <= '0;
        end
        else
        begin
            for (int w = 0; w < 2; w++)
            begin
                if (inv_all)
                    vld_reg[w] <= '0;
                else if (state_reg == ST_INV && way_hit[w])
                    vld_reg[w][cmp_idx] <= 1'b0;
            end
            if (fill_main)
            begin
                vld_reg[rr_reg[idx_reg]][idx_reg] <= 1'b1;
                rr_reg[idx_reg] <= ~rr_reg[idx_reg];
            end
        end
    end

    // Lockdown control, victim and locked valid bits
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            victim_reg   <= VICTIM_RESET;
            preserve_reg <= 1'b0;
            lk_vld_reg   <= '0;
        end
        else
        begin
            if (lock_wr)
            begin
                victim_reg   <= CP_WDATA[VICTIM_LSB +: VICTIM_W];
                preserve_reg <= CP_WDATA[PRESERVE_BIT];
            end
            else if (fill_lock)
            begin
                victim_reg <= victim_reg + 3'h1;
            end
            if (state_reg == ST_INV)
                lk_vld_reg <= lk_vld_reg & ~lk_hit;
            else if (fill_lock)
                lk_vld_reg[victim_reg] <= 1'b1;
        end
    end

    // Locked entry contents need no reset; valid bits gate them
    always_ff @(posedge REF_CLK)
    begin
        if (fill_lock)
            lk_ent[victim_reg] <= walk_entry;
    end

    // Access sequencing
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_reg      <= ST_IDLE;
            ACC_BUSY       <= 1'b0;
            ACC_DONE       <= 1'b0;
            ACC_ABORT      <= 1'b0;
            ACC_PA         <= 32'h0;
            ACC_CACHABLE   <= 1'b0;
            ACC_BUFFERABLE <= 1'b0;
            WALK_REQ       <= 1'b0;
            mva_reg        <= 32'h0;
            wr_reg         <= 1'b0;
            priv_reg       <= 1'b0;
        end
        else
        begin
            ACC_DONE <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                    if (ACC_VALID)
                    begin
                        mva_reg  <= mva_in;
                        wr_reg   <= ACC_WRITE;
                        priv_reg <= ACC_PRIV;
                        if (!MMU_ENABLE)
                        begin
                            ACC_DONE       <= 1'b1;
                            ACC_ABORT      <= 1'b0;
                            ACC_PA         <= ACC_VA;
                            ACC_CACHABLE   <= 1'b0;
                            ACC_BUFFERABLE <= 1'b0;
                        end
                        else
                        begin
                            state_reg <= ST_LOOK;
                            ACC_BUSY  <= 1'b1;
                        end
                    end
                    else if (inv_pend_reg)
                    begin
                        state_reg <= ST_INV;
                        ACC_BUSY  <= 1'b1;
                    end
                ST_LOOK:
                    if (!any_hit)
                    begin
                        state_reg <= ST_WALK;
                        WALK_REQ  <= 1'b1;
                    end
                ST_WALK:
                    if (WALK_DONE)
                        WALK_REQ <= 1'b0;
                ST_INV:
                begin
                    state_reg <= ST_IDLE;
                    ACC_BUSY  <= 1'b0;
                end
            endcase
            if (answer)
            begin
                state_reg      <= ST_IDLE;
                ACC_BUSY       <= 1'b0;
                ACC_DONE       <= 1'b1;
                ACC_ABORT      <= res_abort;
                ACC_PA         <= phys(res_entry, mva_reg);
                ACC_CACHABLE   <= !res_abort && res_entry.cb[1];
                ACC_BUFFERABLE <= !res_abort && res_entry.cb[0];
            end
        end
    end

endmodule

// File: rtl/vrt_pkg.sv
// Constants, entry layout and state codes of the address front end.
// Assumes one 40 MHz core clock and a synchronous active-high reset.
package vrt_pkg;

    // Coprocessor register numbers and secondary opcodes
    localparam logic [3:0] CRN_TLB_OPS  = 4'h8;
    localparam logic [3:0] CRN_LOCKDOWN = 4'hA;
    localparam logic [3:0] CRN_PROCESS  = 4'hD;
    localparam logic [3:0] CRN_RESERVED = 4'hE;
    localparam logic [2:0] OP2_REMAP_ID = 3'h0;
    localparam logic [2:0] OP2_CONTEXT  = 3'h1;
    localparam logic [2:0] OP2_INV_ALL  = 3'h0;
    localparam logic [2:0] OP2_INV_ONE  = 3'h1;

    // Field positions and values after reset
    localparam int         PID_LSB       = 25;
    localparam int         PID_W         = 7;
    localparam logic [6:0] PID_RESET     = 7'h00;
    localparam logic [31:0] CONTEXT_RESET = 32'h00000000;
    localparam int         VICTIM_LSB    = 26;
    localparam int         VICTIM_W      = 3;
    localparam logic [2:0] VICTIM_RESET  = 3'h0;
    localparam int         PRESERVE_BIT  = 0;
    localparam logic [1:0] FETCH_HOLD    = 2'h2;

    // Buffer geometry
    localparam int TLB_SETS     = 32;
    localparam int IDX_W        = 5;
    localparam int IDX_LSB      = 20;
    localparam int LOCK_ENTRIES = 8;
    localparam int PAGE_LSB     = 10;
    localparam int TAG_W        = 22;

    // Mapping sizes and their tag masks
    localparam logic [1:0] SZ_SECTION = 2'h0;
    localparam logic [1:0] SZ_LARGE   = 2'h1;
    localparam logic [1:0] SZ_SMALL   = 2'h2;
    localparam logic [1:0] SZ_TINY    = 2'h3;
    localparam logic [21:0] MASK_SECTION = 22'h3FFC00;
    localparam logic [21:0] MASK_LARGE   = 22'h3FFFC0;
    localparam logic [21:0] MASK_SMALL   = 22'h3FFFFC;
    localparam logic [21:0] MASK_TINY    = 22'h3FFFFF;
    localparam int SUB_LARGE_LSB = 14;
    localparam int SUB_SMALL_LSB = 10;

    // Domain and permission codes
    localparam logic [1:0] DOM_CLIENT  = 2'h1;
    localparam logic [1:0] DOM_MANAGER = 2'h3;
    localparam logic [1:0] AP_NONE     = 2'h0;
    localparam logic [1:0] AP_PRIV     = 2'h1;
    localparam logic [1:0] AP_USER_RO  = 2'h2;

    typedef struct packed {
        logic [21:0] tag;
        logic [21:0] pa;
        logic [1:0]  size;
        logic [3:0]  domain;
        logic [7:0]  ap;
        logic [1:0]  cb;
    } vrt_entry_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOOK = 2'b01,
        ST_WALK = 2'b10,
        ST_INV  = 2'b11
    } vrt_state_t;

endpackage

// File: rtl/vrt_ram_if.sv
// Port bundle between the lookup control and the main buffer memory.
// Both ends run on the core clock.
`timescale 1ns/1ps
interface vrt_ram_if;
    import vrt_pkg::*;
    logic             rd_en;
    logic [IDX_W-1:0] rd_idx;
    vrt_entry_t       rd_data [2];
    logic             wr_en;
    logic             wr_way;
    logic [IDX_W-1:0] wr_idx;
    vrt_entry_t       wr_data;

    modport ctrl (output rd_en, rd_idx, wr_en, wr_way, wr_idx, wr_data,
                  input rd_data);
    modport ram  (input rd_en, rd_idx, wr_en, wr_way, wr_idx, wr_data,
                  output rd_data);
endinterface

// File: rtl/vrt_tlb_ram.sv
// Two-way set-associative entry store with registered read data.
// Valid bits live in the controller so invalidate-all is one cycle.
`timescale 1ns/1ps
module vrt_tlb_ram
    import vrt_pkg::*;
#(
    parameter int SETS_P = TLB_SETS
)(
    // Clock
    input wire logic clk,
    // Memory port
    vrt_ram_if.ram   bus
);

    for (genvar w = 0; w < 2; w++)
    begin : g_way
        vrt_entry_t mem [SETS_P];

        always_ff @(posedge clk)
        begin
            if (bus.wr_en && bus.wr_way == 1'(w))
            begin
                mem[bus.wr_idx] <= bus.wr_data;
            end
            if (bus.rd_en)
            begin
                bus.rd_data[w] <= mem[bus.rd_idx];
            end
        end
    end

endmodule

// File: tb/tb_top.sv
// Testbench: register cases, then access table, then remap and lockdown cases.
// Assumes the walk model answers every walk request.
`timescale 1ns/1ps
module tb_top
    import vrt_pkg::*;
;
    typedef struct packed {
        logic        mmu;
        logic [6:0]  pid;
        logic [31:0] va;
        logic [1:0]  dom;
        logic        abt;
        logic        wk;
    } vrt_row_t;
    logic REF_CLK = 1'h0, RST = 1'h1, CP_VALID = 1'h0, CP_WRITE = 1'h0;
    logic MMU_ENABLE = 1'h0, FETCH_STROBE = 1'h0, ACC_VALID = 1'h0;
    logic ACC_WRITE = 1'h0, ACC_PRIV = 1'h1;
    logic [3:0] CP_CRN = 4'h0;
    logic [2:0] CP_OP2 = 3'h0;
    logic [31:0] CP_WDATA = 32'h0, ACC_VA = 32'h0, DOMAIN_ACCESS = 32'h0;
    logic [31:0] CP_RDATA, ACC_MVA, ACC_PA, WALK_MVA, TRACE_CONTEXT, d, m;
    logic CP_RDVALID, ACC_BUSY, ACC_DONE, ACC_ABORT, ACC_CACHABLE, wk;
    logic ACC_BUFFERABLE, WALK_REQ, TRACE_CONTEXT_WR, WALK_DONE, WALK_FAULT;
    logic [21:0] WALK_BASE;
    logic [1:0] WALK_SIZE, WALK_CB;
    logic [3:0] WALK_DOMAIN;
    logic [7:0] WALK_AP;
    int err_count = 0, total_checks = 0;
    vrt_row_t r;
    vrt_row_t rows [11] = '{
        '{1'h0, 7'h05, 32'h00001234, 2'h3, 1'h0, 1'h0},
        '{1'h1, 7'h00, 32'h00300010, 2'h3, 1'h0, 1'h1},
        '{1'h1, 7'h01, 32'h00300010, 2'h3, 1'h0, 1'h1},
        '{1'h1, 7'h00, 32'h00300010, 2'h3, 1'h0, 1'h0},
        '{1'h1, 7'h00, 32'h00300010, 2'h1, 1'h0, 1'h0},
        '{1'h1, 7'h00, 32'h00300010, 2'h0, 1'h1, 1'h0},
        '{1'h1, 7'h00, 32'h00300010, 2'h2, 1'h1, 1'h0},
        '{1'h1, 7'h05, 32'h02000000, 2'h3, 1'h0, 1'h1},
        '{1'h1, 7'h7F, 32'h01FFFFFC, 2'h3, 1'h1, 1'h1},
        '{1'h1, 7'h00, 32'h08500010, 2'h1, 1'h1, 1'h1},
        '{1'h1, 7'h00, 32'h08500C10, 2'h1, 1'h0, 1'h0}};
    always #12.5 REF_CLK = ~REF_CLK;
    vrt_front DUT (.REF_CLK, .RST, .CP_VALID, .CP_WRITE, .CP_CRN, .CP_OP2,
        .CP_WDATA, .CP_RDATA, .CP_RDVALID, .MMU_ENABLE, .DOMAIN_ACCESS,
        .FETCH_STROBE, .ACC_VALID, .ACC_VA, .ACC_WRITE, .ACC_PRIV,
        .ACC_BUSY, .ACC_DONE, .ACC_ABORT, .ACC_MVA, .ACC_PA, .ACC_CACHABLE,
        .ACC_BUFFERABLE, .WALK_REQ, .WALK_MVA, .WALK_DONE, .WALK_FAULT,
        .WALK_BASE, .WALK_SIZE, .WALK_DOMAIN, .WALK_AP, .WALK_CB,
        .TRACE_CONTEXT, .TRACE_CONTEXT_WR);
    vrt_walk_model u_walk (.clk(REF_CLK), .rst(RST), .req(WALK_REQ),
        .remapped_virtual_address(WALK_MVA), .done(WALK_DONE), .fault(WALK_FAULT),
        .base(WALK_BASE), .size(WALK_SIZE), .cb(WALK_CB),
        .domain(WALK_DOMAIN), .ap(WALK_AP));
    task finish_test();
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task cp(input logic w, input logic [3:0] n, input logic [2:0] o,
            input logic [31:0] wd);
        @(posedge REF_CLK);
        CP_VALID <= 1'h1;
        CP_WRITE <= w;
        CP_CRN <= n;
        CP_OP2 <= o;
        CP_WDATA <= wd;
        @(posedge REF_CLK);
        CP_VALID <= 1'h0;
        #1 d = CP_RDATA;
        // Lets a pending invalidate run to its end
        repeat (4) @(posedge REF_CLK);
    endtask
    task fs();
        @(posedge REF_CLK);
        FETCH_STROBE <= 1'h1;
        @(posedge REF_CLK);
        FETCH_STROBE <= 1'h0;
    endtask
    task pid(input logic [6:0] p);
        cp(1'h1, CRN_PROCESS, OP2_REMAP_ID, {p, 25'h0});
        fs();
        fs();
    endtask
    task acc(input logic [31:0] va, input logic ew);
        int n;
        n = 0;
        wk = 1'h0;
        @(posedge REF_CLK);
        ACC_VA <= va;
        ACC_VALID <= 1'h1;
        @(posedge REF_CLK);
        ACC_VALID <= 1'h0;
        #1;
        while (ACC_DONE !== 1'h1 && n < 50)
        begin
            wk |= WALK_REQ === 1'h1;
            @(posedge REF_CLK);
            #1;
            n++;
        end
        chk({31'h0, ACC_DONE}, 32'h1);
        chk({31'h0, wk}, {31'h0, ew});
    endtask
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        err_count++;
        finish_test();
    end
    initial
    begin
        repeat (16) @(posedge REF_CLK);
        RST <= 1'h0;
        cp(1'h0, CRN_PROCESS, OP2_REMAP_ID, 32'h0);
        chk(d, 32'h0);
        cp(1'h1, CRN_PROCESS, OP2_CONTEXT, 32'hA5C30F96);
        chk(TRACE_CONTEXT, 32'hA5C30F96);
        cp(1'h0, CRN_PROCESS, OP2_CONTEXT, 32'h0);
        chk(d, 32'hA5C30F96);
        cp(1'h0, CRN_RESERVED, 3'h0, 32'h0);
        chk(d, 32'h0);
        foreach (rows[i])
        begin
            r = rows[i];
            @(posedge REF_CLK);
            MMU_ENABLE <= r.mmu;
            DOMAIN_ACCESS <= {30'h0, r.dom};
            pid(r.pid);
            acc(r.va, r.wk);
            m = (r.mmu && r.va[31:25] == 7'h00) ? r.va + {r.pid, 25'h0} : r.va;
            chk(ACC_MVA, m);
            chk({31'h0, ACC_ABORT}, {31'h0, r.abt});
            chk({31'h0, ACC_BUFFERABLE}, {31'h0, r.mmu & ~r.abt});
            chk({31'h0, ACC_CACHABLE}, {31'h0, r.mmu & ~r.abt});
            if (!r.abt)
                chk(ACC_PA, r.mmu ? m + 32'h00100000 : r.va);
        end
        pid(7'h00);
        cp(1'h1, CRN_PROCESS, OP2_REMAP_ID, 32'h06000000);
        fs();
        acc(32'h00300010, 1'h0);
        chk(ACC_MVA, 32'h00300010);
        fs();
        acc(32'h00300010, 1'h1);
        chk(ACC_MVA, 32'h06300010);
        pid(7'h00);
        cp(1'h1, CRN_LOCKDOWN, 3'h0, 32'h1C000001);
        acc(32'h04300010, 1'h1);
        chk(ACC_PA, 32'h04400010);
        cp(1'h0, CRN_LOCKDOWN, 3'h0, 32'h0);
        chk(d, 32'h00000001);
        cp(1'h1, CRN_TLB_OPS, OP2_INV_ALL, 32'h0);
        acc(32'h04300010, 1'h0);
        acc(32'h00300010, 1'h1);
        pid(7'h01);
        cp(1'h1, CRN_TLB_OPS, OP2_INV_ONE, 32'h00300010);
        pid(7'h00);
        acc(32'h00300010, 1'h1);
        // Reset in mid-run must drop id, lockdown state and locked entries
        pid(7'h09);
        @(posedge REF_CLK);
        RST <= 1'h1;
        repeat (3) @(posedge REF_CLK);
        RST <= 1'h0;
        cp(1'h0, CRN_PROCESS, OP2_REMAP_ID, 32'h0);
        chk(d, 32'h0);
        chk(TRACE_CONTEXT, CONTEXT_RESET);
        cp(1'h0, CRN_LOCKDOWN, 3'h0, 32'h0);
        chk(d, 32'h0);
        acc(32'h04300010, 1'h1);
        finish_test();
    end
endmodule

// File: tb/vrt_front_assertions.sv
// Port-level checks of the address front end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module vrt_front_assertions
    import vrt_pkg::*;
(
    // Clock, reset, coprocessor, trace
    input wire logic REF_CLK, RST, CP_VALID, CP_WRITE, CP_RDVALID,
    input wire logic [3:0] CP_CRN,
    input wire logic [2:0] CP_OP2,
    input wire logic [31:0] CP_WDATA, TRACE_CONTEXT,
    input wire logic TRACE_CONTEXT_WR,
    // Access and walk
    input wire logic MMU_ENABLE, ACC_VALID, ACC_BUSY, ACC_DONE,
    input wire logic ACC_ABORT, ACC_CACHABLE, WALK_REQ, WALK_DONE,
    input wire logic [31:0] ACC_VA, ACC_MVA, ACC_PA, WALK_MVA
);
    logic ctx_q;
    // Registered so the strobe can be tied back to its cause
    always_ff @(posedge REF_CLK)
        ctx_q <= CP_VALID && CP_WRITE && CP_CRN == CRN_PROCESS
                 && CP_OP2 == OP2_CONTEXT;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_take;
        ACC_VALID && !ACC_BUSY;
    endsequence
    a_off_fast: assert property (s_take ##0 !MMU_ENABLE
        |=> ACC_DONE && ACC_PA == $past(ACC_VA)) else $error("bypass bad");
    a_high_pass: assert property (s_take ##0 ACC_VA[31:25] != 7'h00
        |=> ACC_MVA == $past(ACC_VA)) else $error("high addr moved");
    a_ctx_mirror: assert property (ctx_q |-> TRACE_CONTEXT_WR
        && TRACE_CONTEXT == $past(CP_WDATA)) else $error("context bad");
    a_ctx_strobe: assert property (TRACE_CONTEXT_WR |-> ctx_q)
        else $error("stray context strobe");
    a_read_pulse: assert property (CP_VALID && !CP_WRITE
        |=> CP_RDVALID) else $error("read answer missing");
    a_hit_or_walk: assert property (s_take ##0 MMU_ENABLE
        |=> ACC_BUSY ##1 (ACC_DONE || WALK_REQ)) else $error("lookup late");
    a_walk_end: assert property (WALK_REQ && WALK_DONE
        |=> ACC_DONE && !WALK_REQ) else $error("walk end bad");
    // Request must stand, busy and on one address, until answered
    a_walk_hold: assert property (WALK_REQ && !WALK_DONE
        |=> WALK_REQ && ACC_BUSY && $stable(WALK_MVA))
        else $error("walk request dropped");
    a_abort_nc: assert property (ACC_DONE && ACC_ABORT
        |-> !ACC_CACHABLE) else $error("aborted but cachable");
endmodule
bind vrt_front vrt_front_assertions u_chk (.REF_CLK, .RST, .CP_VALID,
    .CP_WRITE, .CP_RDVALID, .CP_CRN, .CP_OP2, .CP_WDATA, .TRACE_CONTEXT,
    .TRACE_CONTEXT_WR, .MMU_ENABLE, .ACC_VALID, .ACC_BUSY, .ACC_DONE,
    .ACC_ABORT, .ACC_CACHABLE, .WALK_REQ, .WALK_DONE, .ACC_VA, .ACC_MVA,
    .ACC_PA, .WALK_MVA);

// File: tb/vrt_walk_model.sv
// Table walker model: PA = REMAPPED_VIRTUAL_ADDRESS + 1MB, sections unless REMAPPED_VIRTUAL_ADDRESS bit 27 is set.
// REMAPPED_VIRTUAL_ADDRESS bit 26 makes a slow walk, top nibble F a faulting one.
`timescale 1ns/1ps
module vrt_walk_model
    import vrt_pkg::*;
(
    // Clock, reset and request
    input wire logic clk, rst, req,
    input wire logic [31:0] remapped_virtual_address,
    // Answer
    output logic done, fault,
    output logic [21:0] base,
    output logic [1:0] size, cb,
    output logic [3:0] domain,
    output logic [7:0] ap
);
    logic [2:0] cnt_reg;
    logic [2:0] lat;
    assign lat = remapped_virtual_address[26] ? 3'h5 : 3'h1;
    always_ff @(posedge clk)
        cnt_reg <= (rst || !req || done) ? 3'h0 : cnt_reg + 3'h1;
    always_ff @(posedge clk)
        done <= !rst && req && !done && cnt_reg == lat;
    // Idle lines flip, so a stale entry is never mistaken for live
    assign fault = done && remapped_virtual_address[31:28] == 4'hF;
    assign base = done ? remapped_virtual_address[31:10] + 22'h000400 : ~remapped_virtual_address[31:10];
    assign size = done ? (remapped_virtual_address[27] ? SZ_SMALL : SZ_SECTION) : SZ_TINY;
    assign domain = done ? 4'h0 : 4'hF;
    // Small pages: subpage k carries access code k
    assign ap = done ? (remapped_virtual_address[27] ? 8'hE4 : 8'hFF) : 8'h00;
    assign cb = done ? 2'h3 : 2'h0;
endmodule
